/* core/irq_status.sv */
// Read-to-clear under-voltage, overcurrent and pin event status registers.
//
// How it works
// - Linear regulator under-voltage flags, bits 8-11.
// - Converter under-voltage rising edges, bits 0-5.
// - Limit switch overcurrent edge latched, bit 15.
// - Pin flags 0-12, per-pin configured trigger.
// - Reading a status register clears it.
// - Group masks: 1 blocks, reset to 1.
`default_nettype none
module irq_status (
  input  wire logic                                      clk,
  input  wire logic                                      rst_n,
  input  wire logic [irq_status_pkg::LINREG_COUNT-1:0]   linreg_undervolt,
  input  wire logic [irq_status_pkg::CONV_COUNT-1:0]     conv_undervolt,
  input  wire logic                                      limit_switch_overcurrent,
  input  wire logic [irq_status_pkg::PIN_COUNT-1:0]      pin_source,
  input  wire logic [irq_status_pkg::PIN_COUNT-1:0]      pin_level_mode,
  input  wire logic [irq_status_pkg::PIN_COUNT-1:0]      pin_active_high,
  input  wire logic [irq_status_pkg::PIN_COUNT-1:0]      pin_both_edges,
  input  wire irq_status_pkg::reg_addr_type              reg_addr,
  input  wire logic                                      reg_rd_strobe,
  input  wire logic                                      reg_wr_strobe,
  input  wire irq_status_pkg::reg_data_type              reg_wr_data,
  output irq_status_pkg::reg_data_type                   reg_rd_data,
  output logic                                           undervolt_irq,
  output logic                                           overcurrent_irq,
  output logic                                           pin_irq
);
  import irq_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  localparam int UV_WIDTH = LINREG_COUNT + CONV_COUNT;

  logic [UV_WIDTH-1:0]     uv_source;
  logic [UV_WIDTH-1:0]     uv_flags_reg;
  logic [0:0]              oc_flags_reg;
  logic [PIN_COUNT-1:0]    pin_flags_reg;
  logic                    linreg1_undervolt_flag;
  logic                    linreg2_undervolt_flag;
  logic                    linreg3_undervolt_flag;
  logic                    linreg4_undervolt_flag;
  logic                    conv1_undervolt_flag;
  logic                    conv2_undervolt_flag;
  logic                    conv3_undervolt_flag;
  logic                    conv4_undervolt_flag;
  logic                    conv5_undervolt_flag;
  logic                    conv6_undervolt_flag;
  logic                    limit_switch_overcurrent_flag;
  logic                    pin0_event_flag;
  logic                    pin1_event_flag;
  logic                    pin2_event_flag;
  logic                    pin3_event_flag;
  logic                    pin4_event_flag;
  logic                    pin5_event_flag;
  logic                    pin6_event_flag;
  logic                    pin7_event_flag;
  logic                    pin8_event_flag;
  logic                    pin9_event_flag;
  logic                    pin10_event_flag;
  logic                    pin11_event_flag;
  logic                    pin12_event_flag;
  logic                    rd_uv;
  logic                    rd_oc;
  logic                    rd_pin;
  logic                    undervolt_group_mask_reg;
  logic                    overcurrent_group_mask_reg;
  logic                    pin_group_mask_reg;
  reg_data_type            uv_word;
  reg_data_type            oc_word;
  reg_data_type            pin_word;
  reg_data_type            mask_word;
  reg_data_type            reg_rd_data_next;

  // True when a strobe hits the given register offset.
  function automatic logic hit_addr(input reg_addr_type addr, input reg_addr_type target,
                                    input logic strobe);
    hit_addr = strobe && (addr == target);
  endfunction : hit_addr

  // A group signals while any flag is set and its mask is open.
  function automatic logic group_active(input logic any_flag, input logic mask);
    group_active = any_flag && !mask;
  endfunction : group_active

  assign rd_uv  = hit_addr(reg_addr, UNDERVOLT_STATUS_ADDR, reg_rd_strobe);
  assign rd_oc  = hit_addr(reg_addr, OVERCURRENT_STATUS_ADDR, reg_rd_strobe);
  assign rd_pin = hit_addr(reg_addr, PIN_STATUS_ADDR, reg_rd_strobe);

  ////////////////////////////////////////////////////////////////////////////

  // Converters sit in the low bits, regulators above them.
  assign uv_source = {linreg_undervolt, conv_undervolt};

  // Fault sources are fixed rising-edge triggers.
  event_latch #(
    .WIDTH (UV_WIDTH)
  ) undervolt_latch (
    .clk         (clk),
    .rst_n       (rst_n),
    .source      (uv_source),
    .level_mode  ({UV_WIDTH{1'b0}}),
    .active_high ({UV_WIDTH{1'b1}}),
    .both_edges  ({UV_WIDTH{1'b0}}),
    .read_clear  (rd_uv),
    .flags_reg   (uv_flags_reg)
  );

  event_latch #(
    .WIDTH (1)
  ) overcurrent_latch (
    .clk         (clk),
    .rst_n       (rst_n),
    .source      (limit_switch_overcurrent),
    .level_mode  (1'b0),
    .active_high (1'b1),
    .both_edges  (1'b0),
    .read_clear  (rd_oc),
    .flags_reg   (oc_flags_reg)
  );

  // The per-pin trigger configuration lives outside and arrives as levels.
  event_latch #(
    .WIDTH (PIN_COUNT)
  ) pin_latch (
    .clk         (clk),
    .rst_n       (rst_n),
    .source      (pin_source),
    .level_mode  (pin_level_mode),
    .active_high (pin_active_high),
    .both_edges  (pin_both_edges),
    .read_clear  (rd_pin),
    .flags_reg   (pin_flags_reg)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Each flag keeps its field name from the latch to the register word.
  assign {linreg4_undervolt_flag,
          linreg3_undervolt_flag,
          linreg2_undervolt_flag,
          linreg1_undervolt_flag,
          conv6_undervolt_flag,
          conv5_undervolt_flag,
          conv4_undervolt_flag,
          conv3_undervolt_flag,
          conv2_undervolt_flag,
          conv1_undervolt_flag} = uv_flags_reg;
  assign limit_switch_overcurrent_flag = oc_flags_reg[0];
  assign {pin12_event_flag,
          pin11_event_flag,
          pin10_event_flag,
          pin9_event_flag,
          pin8_event_flag,
          pin7_event_flag,
          pin6_event_flag,
          pin5_event_flag,
          pin4_event_flag,
          pin3_event_flag,
          pin2_event_flag,
          pin1_event_flag,
          pin0_event_flag} = pin_flags_reg;

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      undervolt_group_mask_reg   <= MASK_RESET;
      overcurrent_group_mask_reg <= MASK_RESET;
      pin_group_mask_reg         <= MASK_RESET;
    end else if (hit_addr(reg_addr, GROUP_MASK_ADDR, reg_wr_strobe)) begin
      undervolt_group_mask_reg   <= reg_wr_data[UNDERVOLT_MASK_BIT];
      overcurrent_group_mask_reg <= reg_wr_data[OVERCURRENT_MASK_BIT];
      pin_group_mask_reg         <= reg_wr_data[PIN_MASK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    uv_word   = STATUS_RESET;
    oc_word   = STATUS_RESET;
    pin_word  = STATUS_RESET;
    mask_word = READ_ZERO;
    uv_word[LINREG_FLAG_LSB +: LINREG_COUNT] = {linreg4_undervolt_flag, linreg3_undervolt_flag,
                                                linreg2_undervolt_flag, linreg1_undervolt_flag};
    uv_word[CONV_FLAG_LSB +: CONV_COUNT]     = {conv6_undervolt_flag, conv5_undervolt_flag,
                                                conv4_undervolt_flag, conv3_undervolt_flag,
                                                conv2_undervolt_flag, conv1_undervolt_flag};
    oc_word[OVERCURRENT_FLAG_BIT]            = limit_switch_overcurrent_flag;
    pin_word[PIN_FLAG_LSB +: PIN_COUNT]      = {pin12_event_flag, pin11_event_flag,
                                                pin10_event_flag, pin9_event_flag,
                                                pin8_event_flag, pin7_event_flag,
                                                pin6_event_flag, pin5_event_flag,
                                                pin4_event_flag, pin3_event_flag,
                                                pin2_event_flag, pin1_event_flag,
                                                pin0_event_flag};
    mask_word[UNDERVOLT_MASK_BIT]            = undervolt_group_mask_reg;
    mask_word[OVERCURRENT_MASK_BIT]          = overcurrent_group_mask_reg;
    mask_word[PIN_MASK_BIT]                  = pin_group_mask_reg;
  end

  // The word returned is the one sampled in the clearing cycle, so the host
  // sees exactly the flags it clears; later events wait for the next read.
  always_comb begin
    reg_rd_data_next = reg_rd_data;
    if (reg_rd_strobe) begin
      unique case (reg_addr)
        UNDERVOLT_STATUS_ADDR:   reg_rd_data_next = uv_word;
        OVERCURRENT_STATUS_ADDR: reg_rd_data_next = oc_word;
        PIN_STATUS_ADDR:         reg_rd_data_next = pin_word;
        GROUP_MASK_ADDR:         reg_rd_data_next = mask_word;
        default:                 reg_rd_data_next = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= READ_ZERO;
    end else begin
      reg_rd_data <= reg_rd_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      undervolt_irq   <= 1'b0;
      overcurrent_irq <= 1'b0;
      pin_irq         <= 1'b0;
    end else begin
      undervolt_irq   <= group_active(|uv_flags_reg, undervolt_group_mask_reg);
      overcurrent_irq <= group_active(oc_flags_reg[0], overcurrent_group_mask_reg);
      pin_irq         <= group_active(|pin_flags_reg, pin_group_mask_reg);
    end
  end

endmodule : irq_status
`default_nettype wire

/* core/irq_status_pkg.sv */
// Package holding the register map and field layout of the fault and pin event status block.
`default_nettype none
package irq_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  typedef logic [ADDR_W-1:0] reg_addr_type;
  typedef logic [DATA_W-1:0] reg_data_type;

  // Register offsets.
  localparam reg_addr_type UNDERVOLT_STATUS_ADDR = 8'h1c;
  localparam reg_addr_type OVERCURRENT_STATUS_ADDR = 8'h1d;
  localparam reg_addr_type PIN_STATUS_ADDR = 8'h1e;
  localparam reg_addr_type GROUP_MASK_ADDR = 8'h20;

  // Source counts.
  localparam int LINREG_COUNT = 4;
  localparam int CONV_COUNT = 6;
  localparam int PIN_COUNT = 13;

  // Field positions.
  localparam int LINREG_FLAG_LSB = 8;
  localparam int CONV_FLAG_LSB = 0;
  localparam int OVERCURRENT_FLAG_BIT = 15;
  localparam int PIN_FLAG_LSB = 0;
  localparam int UNDERVOLT_MASK_BIT = 12;
  localparam int OVERCURRENT_MASK_BIT = 13;
  localparam int PIN_MASK_BIT = 6;

  // Reset values.
  localparam reg_data_type STATUS_RESET = 16'h0000;
  localparam logic MASK_RESET = 1'b1;
  localparam reg_data_type READ_ZERO = 16'h0000;

endpackage : irq_status_pkg
`default_nettype wire

/* core/event_latch.sv */
// Sticky event flags with configurable trigger and read-to-clear.
`default_nettype none
module event_latch #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] source,
  input  wire logic [WIDTH-1:0] level_mode,
  input  wire logic [WIDTH-1:0] active_high,
  input  wire logic [WIDTH-1:0] both_edges,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] flags_reg
);

  logic [WIDTH-1:0] source_prev_reg;
  logic             primed_reg;
  logic [WIDTH-1:0] hit;
  logic [WIDTH-1:0] flags_next;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      source_prev_reg <= '0;
      primed_reg      <= 1'b0;
    end else begin
      source_prev_reg <= source;
      primed_reg      <= 1'b1;
    end
  end

  // Edges are ignored until one sample has been taken, so a source that is
  // already high when reset lifts does not raise a false flag.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (level_mode[i]) begin
        hit[i] = source[i] == active_high[i];
      end else if (both_edges[i]) begin
        hit[i] = primed_reg && (source[i] != source_prev_reg[i]);
      end else if (active_high[i]) begin
        hit[i] = primed_reg && source[i] && !source_prev_reg[i];
      end else begin
        hit[i] = primed_reg && !source[i] && source_prev_reg[i];
      end
    end
  end

  // A new event wins over the clear of the same cycle.
  assign flags_next = (read_clear ? '0 : flags_reg) | hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule : event_latch
`default_nettype wire

/* bench/irq_status_properties.sv */
// Concurrent checks on the status block's register and interrupt ports.
`default_nettype none
module irq_status_properties
  import irq_status_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [LINREG_COUNT-1:0] linreg_undervolt,
  input wire logic [CONV_COUNT-1:0]   conv_undervolt,
  input wire logic                    limit_switch_overcurrent,
  input wire reg_addr_type            reg_addr,
  input wire logic                    reg_rd_strobe,
  input wire logic                    reg_wr_strobe,
  input wire reg_data_type            reg_wr_data,
  input wire reg_data_type            reg_rd_data,
  input wire logic                    undervolt_irq,
  input wire logic                    overcurrent_irq,
  input wire logic                    pin_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic uv_rd = reg_rd_strobe && reg_addr == UNDERVOLT_STATUS_ADDR;
  wire logic oc_rd = reg_rd_strobe && reg_addr == OVERCURRENT_STATUS_ADDR;
  wire logic mask_wr = reg_wr_strobe && reg_addr == GROUP_MASK_ADDR;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_rd_data_holds: assert property (!reg_rd_strobe |=> $stable(reg_rd_data))
    else $error("Read data moved without a read.");
  a_uv_field_layout: assert property (uv_rd |=> (reg_rd_data & 16'hf0c0) == READ_ZERO)
    else $error("Unused under-voltage bits set.");
  a_oc_field_layout: assert property (oc_rd |=> (reg_rd_data & 16'h7fff) == READ_ZERO)
    else $error("Unused overcurrent bits set.");
  a_pin_field_layout: assert property (reg_rd_strobe && reg_addr == PIN_STATUS_ADDR
    |=> reg_rd_data[15:13] == 3'b000) else $error("Unused pin bits set.");
  a_mask_field_layout: assert property (reg_rd_strobe && reg_addr == GROUP_MASK_ADDR
    |=> (reg_rd_data & 16'hcfbf) == READ_ZERO) else $error("Unused mask bits set.");
  // Sources held still over both reads, so nothing may refill the flags in between.
  a_uv_read_clears: assert property (uv_rd && $stable({linreg_undervolt, conv_undervolt})
    ##1 uv_rd && $stable({linreg_undervolt, conv_undervolt}) |=> reg_rd_data == READ_ZERO)
    else $error("Second under-voltage read not clear.");
  a_oc_read_clears: assert property (oc_rd && $stable(limit_switch_overcurrent)
    ##1 oc_rd && $stable(limit_switch_overcurrent) |=> reg_rd_data == READ_ZERO)
    else $error("Second overcurrent read not clear.");
  a_uv_mask_blocks: assert property (mask_wr && reg_wr_data[UNDERVOLT_MASK_BIT]
    |-> ##2 !undervolt_irq) else $error("Masked under-voltage interrupt raised.");
  a_pin_mask_blocks: assert property (mask_wr && reg_wr_data[PIN_MASK_BIT]
    |-> ##2 !pin_irq) else $error("Masked pin interrupt raised.");
  a_oc_mask_blocks: assert property (mask_wr && reg_wr_data[OVERCURRENT_MASK_BIT]
    |-> ##2 !overcurrent_irq) else $error("Masked overcurrent interrupt raised.");
endmodule : irq_status_properties
bind irq_status irq_status_properties chk (
  .clk(clk), .rst_n(rst_n), .linreg_undervolt(linreg_undervolt),
  .conv_undervolt(conv_undervolt), .limit_switch_overcurrent(limit_switch_overcurrent),
  .reg_addr(reg_addr), .reg_rd_strobe(reg_rd_strobe), .reg_wr_strobe(reg_wr_strobe),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .undervolt_irq(undervolt_irq),
  .overcurrent_irq(overcurrent_irq), .pin_irq(pin_irq)
);
`default_nettype wire

/* bench/host_model.sv */
// Host model driving the status block's register strobes.
`default_nettype none
module host_model
  import irq_status_pkg::*;
(
  input  wire logic         clk,
  output var reg_addr_type  reg_addr,
  output var logic          reg_rd_strobe,
  output var logic          reg_wr_strobe,
  output var reg_data_type  reg_wr_data,
  input  wire reg_data_type reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_rd_strobe = 1'b0;
    reg_wr_strobe = 1'b0;
    reg_wr_data = 16'h0000;
  end
  // Entered at a falling edge; strobes never overlap and an idle cycle ends each access.
  task automatic reg_read(input reg_addr_type a, input bit twice, output reg_data_type d0, d1);
    reg_addr = a;
    reg_rd_strobe = 1'b1;
    @(negedge clk) d0 = reg_rd_data;
    if (!twice) reg_rd_strobe = 1'b0;
    @(negedge clk) d1 = reg_rd_data;
    reg_rd_strobe = 1'b0;
    @(negedge clk);
  endtask : reg_read
  task automatic reg_write(input reg_addr_type a, input reg_data_type d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_strobe = 1'b1;
    @(negedge clk) reg_wr_strobe = 1'b0;
    @(negedge clk);
  endtask : reg_write
endmodule : host_model
`default_nettype wire

/* bench/tb_irq_status.sv */
// Self-checking testbench for the fault and pin event status block.
`default_nettype none
module tb_irq_status
  import irq_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, limit_switch_overcurrent, undervolt_irq, overcurrent_irq, pin_irq;
  logic [LINREG_COUNT-1:0] linreg_undervolt;
  logic [CONV_COUNT-1:0]   conv_undervolt;
  logic [PIN_COUNT-1:0]    pin_source, pin_level_mode, pin_active_high, pin_both_edges;
  logic                    reg_rd_strobe, reg_wr_strobe;
  reg_addr_type            reg_addr;
  reg_data_type            reg_wr_data, reg_rd_data, d0, d1, e;
  int                      bad_count, comparisons;
  irq_status dut (
    .clk(clk), .rst_n(rst_n), .linreg_undervolt(linreg_undervolt),
    .conv_undervolt(conv_undervolt), .limit_switch_overcurrent(limit_switch_overcurrent),
    .pin_source(pin_source), .pin_level_mode(pin_level_mode), .pin_active_high(pin_active_high),
    .pin_both_edges(pin_both_edges), .reg_addr(reg_addr), .reg_rd_strobe(reg_rd_strobe),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .undervolt_irq(undervolt_irq), .overcurrent_irq(overcurrent_irq), .pin_irq(pin_irq)
  );
  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_rd_strobe(reg_rd_strobe),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_data(input reg_data_type got, input reg_data_type exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: data %h, expected %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: interrupt %b, expected %b", $time, got, exp);
    end
  endtask : check_bit
  // A single read also checks that the data holds for the idle cycle after it.
  task automatic check_read(input reg_addr_type a, input bit twice, input reg_data_type e0, e1);
    host.reg_read(a, twice, d0, d1);
    check_data(d0, e0);
    check_data(d1, e1);
  endtask : check_read
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    linreg_undervolt = 4'h0;
    conv_undervolt = 6'h00;
    limit_switch_overcurrent = 1'b0;
    pin_source = 13'h0012;
    pin_level_mode = 13'h0018;
    pin_active_high = 13'h1009;
    pin_both_edges = 13'h0004;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    host.reg_write(UNDERVOLT_STATUS_ADDR, 16'hffff);
    check_read(UNDERVOLT_STATUS_ADDR, 1'b0, STATUS_RESET, STATUS_RESET);
    check_read(OVERCURRENT_STATUS_ADDR, 1'b0, 16'h0000, 16'h0000);
    check_read(PIN_STATUS_ADDR, 1'b0, 16'h0000, 16'h0000);
    check_read(GROUP_MASK_ADDR, 1'b0, 16'h3040, 16'h3040);
    check_read(8'h1f, 1'b0, READ_ZERO, READ_ZERO);
    for (int i = 0; i < 10; i++) begin
      {linreg_undervolt, conv_undervolt} = 10'h001 << i;
      e = (i < 6) ? (16'h0001 << i) : (16'h0001 << (i + 2));
      @(negedge clk);
      check_read(UNDERVOLT_STATUS_ADDR, 1'b1, e, 16'h0000);
      {linreg_undervolt, conv_undervolt} = 10'h000;
      @(negedge clk);
    end
    conv_undervolt = 6'h01;
    check_read(UNDERVOLT_STATUS_ADDR, 1'b1, 16'h0000, 16'h0001);
    limit_switch_overcurrent = 1'b1;
    @(negedge clk);
    check_read(OVERCURRENT_STATUS_ADDR, 1'b1, 16'h8000, 16'h0000);
    limit_switch_overcurrent = 1'b0;
    pin_source = 13'h101d;
    @(negedge clk);
    check_read(PIN_STATUS_ADDR, 1'b0, 16'h100f, 16'h100f);
    pin_source = 13'h1009;
    @(negedge clk);
    check_read(PIN_STATUS_ADDR, 1'b0, 16'h001c, 16'h001c);
    linreg_undervolt = 4'h1;
    @(negedge clk);
    @(negedge clk);
    check_bit(undervolt_irq, 1'b0);
    host.reg_write(GROUP_MASK_ADDR, 16'h0000);
    check_bit(undervolt_irq, 1'b1);
    check_bit(pin_irq, 1'b1);
    check_bit(overcurrent_irq, 1'b0);
    limit_switch_overcurrent = 1'b1;
    repeat (2) @(negedge clk);
    check_bit(overcurrent_irq, 1'b1);
    host.reg_write(GROUP_MASK_ADDR, 16'h3040);
    check_bit(undervolt_irq, 1'b0);
    check_bit(overcurrent_irq, 1'b0);
    check_read(UNDERVOLT_STATUS_ADDR, 1'b0, 16'h0100, 16'h0100);
    host.reg_write(GROUP_MASK_ADDR, 16'h0000);
    // Reset again with sources still high: the release must not look like an edge.
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check_bit(overcurrent_irq, 1'b0);
    check_bit(pin_irq, 1'b0);
    check_read(GROUP_MASK_ADDR, 1'b0, 16'h3040, 16'h3040);
    check_read(UNDERVOLT_STATUS_ADDR, 1'b0, 16'h0000, 16'h0000);
    print_verdict();
  end
endmodule : tb_irq_status
`default_nettype wire
